/* core/gcicr_regs.sv */
// Top: GPIO pin, clock select, RTC polarity and interrupt routing config registers
//
// Operation
// - Pin config bit 0: 1 input, 0 output
// - Pin config bit 1: 1 inverts pin level
// - Pin config bit 7: 1 open-drain, 0 push-pull
// - Clock bit 0: 1 means no slow clock fitted
// - Slow clock absent: derive it from 14 MHz
// - Clock bit 1: 1 stops and gates key-wake logic
// - Clock bit 2: 1 switches 40 MHz output off
// - RTC polarity bit 0: 1 makes interrupt active low
// - Routing bits 7:4 pick input B's interrupt
// - Routing bits 3:0 pick input A's interrupt
// - Code 0 none, 1-15 interrupts; 2 shared
`timescale 1ns/1ps
module gcicr_regs (
    // Clock and standby power-on reset
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    // Register port
    input  gcicr_pkg::gcicr_bus_req_s      bus_req,
    output logic [7:0]                     rdata_ff,
    // GPIO pins
    input  wire logic [5:0]                gpio_pin_in,
    output logic [5:0]                     gpio_pin_out_ff,
    output logic [5:0]                     gpio_pin_oe_n_ff,
    // GPIO internal values
    input  wire logic [5:0]                gpio_core_out,
    output logic [5:0]                     gpio_core_in_ff,
    // Clock inputs and outputs
    input  wire logic                      slow_clock_in,
    input  wire logic                      fast_ref_in,
    output logic                           slow_clk_out_ff,
    output logic                           key_wake_clk_ff,
    output logic                           specific_key_wake_off_ff,
    output logic                           fast_clock_out_en_ff,
    // RTC interrupt
    input  wire logic                      rtc_irq_in,
    output logic                           rtc_irq_out_ff,
    // External interrupt inputs and serial interrupt requests
    input  wire logic                      ext_interrupt_in_a,
    input  wire logic                      ext_interrupt_in_b,
    output logic [15:0]                    serirq_req_ff,
    output logic                           irq2_routed_ff
);
    localparam int unsigned NP = gcicr_pkg::NUM_PINS;

    // Config registers
    gcicr_pkg::gcicr_pin_cfg_s gpio_cfg_ff   [NP];
    gcicr_pkg::gcicr_pin_cfg_s nxt_gpio_cfg  [NP];
    gcicr_pkg::gcicr_clk_sel_s clk_sel_ff;
    gcicr_pkg::gcicr_clk_sel_s nxt_clk_sel;
    logic [7:0]                rtc_pol_ff;
    logic [7:0]                nxt_rtc_pol;
    gcicr_pkg::gcicr_route_s   route_ff;
    gcicr_pkg::gcicr_route_s   nxt_route;
    logic [7:0]                nxt_rdata;

    // Synchronised pin levels: 5:0 gpio, 6 slow clock, 7 input A, 8 input B
    logic [8:0]                sync_lvl;

    gcicr_sync #(
        .WIDTH    (9)
    ) u_sync (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .async_in ({ext_interrupt_in_b, ext_interrupt_in_a, slow_clock_in, gpio_pin_in}),
        .level_ff (sync_lvl)
    );

    // Register writes
    always_comb
    begin
        for (int i = 0; i < NP; i++)
        begin
            nxt_gpio_cfg[i] = gpio_cfg_ff[i];
            if (bus_req.wr && bus_req.addr == gcicr_pkg::GPIO_OFS[i])
                nxt_gpio_cfg[i] = bus_req.wdata & gcicr_pkg::MASK_GPIO_CTRL;
        end
        nxt_clk_sel = clk_sel_ff;
        nxt_rtc_pol = rtc_pol_ff;
        nxt_route   = route_ff;
        if (bus_req.wr)
        begin
            unique case (bus_req.addr)
                gcicr_pkg::OFS_CLOCK_SOURCE_CTRL:
                    nxt_clk_sel = bus_req.wdata & gcicr_pkg::MASK_CLOCK_CTRL;
                gcicr_pkg::OFS_RTC_IRQ_POLARITY:
                    nxt_rtc_pol = bus_req.wdata & gcicr_pkg::MASK_RTC_POL;
                gcicr_pkg::OFS_IRQ_INPUT_ROUTING:
                    nxt_route   = bus_req.wdata & gcicr_pkg::MASK_IRQ_ROUTING;
                default:
                    nxt_route   = route_ff;
            endcase
        end
    end

    // Only the standby power-on reset clears the bank
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NP; i++)
                gpio_cfg_ff[i] <= gcicr_pkg::RST_GPIO_CTRL;
            clk_sel_ff <= gcicr_pkg::RST_CLOCK_CTRL;
            rtc_pol_ff <= gcicr_pkg::RST_RTC_POL;
            route_ff   <= gcicr_pkg::RST_IRQ_ROUTING;
        end
        else
        begin
            for (int i = 0; i < NP; i++)
                gpio_cfg_ff[i] <= nxt_gpio_cfg[i];
            clk_sel_ff <= nxt_clk_sel;
            rtc_pol_ff <= nxt_rtc_pol;
            route_ff   <= nxt_route;
        end
    end

    // Read data, valid only in the cycle after the strobe
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (bus_req.rd)
        begin
            for (int i = 0; i < NP; i++)
                if (bus_req.addr == gcicr_pkg::GPIO_OFS[i])
                    nxt_rdata = gpio_cfg_ff[i];
            unique case (bus_req.addr)
                gcicr_pkg::OFS_CLOCK_SOURCE_CTRL: nxt_rdata = clk_sel_ff;
                gcicr_pkg::OFS_RTC_IRQ_POLARITY:  nxt_rdata = rtc_pol_ff;
                gcicr_pkg::OFS_IRQ_INPUT_ROUTING: nxt_rdata = route_ff;
                gcicr_pkg::OFS_PIN_LEVEL_STATUS:  nxt_rdata = {2'h0, gpio_core_in_ff};
                default:                          nxt_rdata = nxt_rdata;
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    // Per-pin direction, polarity and driver type
    logic [5:0] nxt_pin_out;
    logic [5:0] nxt_pin_oe_n;
    logic [5:0] nxt_core_in;
    logic [5:0] cfg_in;
    logic [5:0] cfg_inv;
    logic [5:0] cfg_od;

    for (genvar g = 0; g < NP; g++)
    begin : g_pin
        assign cfg_in[g]  = gpio_cfg_ff[g].is_input;
        assign cfg_inv[g] = gpio_cfg_ff[g].invert;
        assign cfg_od[g]  = gpio_cfg_ff[g].open_drain;
        assign nxt_pin_out[g]  = gpio_core_out[g] ^ cfg_inv[g];
        // Open-drain releases the pin for a high level
        assign nxt_pin_oe_n[g] = cfg_in[g] | (cfg_od[g] & nxt_pin_out[g]);
        assign nxt_core_in[g]  = sync_lvl[g] ^ cfg_inv[g];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            gpio_pin_out_ff  <= 6'h00;
            gpio_pin_oe_n_ff <= 6'h3F;
            gpio_core_in_ff  <= 6'h00;
        end
        else
        begin
            gpio_pin_out_ff  <= nxt_pin_out;
            gpio_pin_oe_n_ff <= nxt_pin_oe_n;
            gpio_core_in_ff  <= nxt_core_in;
        end
    end

    // Slow clock source and divider from the 14 MHz reference
    localparam logic [7:0] DIV_LAST = 8'(gcicr_pkg::SLOW_HALF_EDGES - 1);

    logic [7:0] div_cnt_ff;
    logic [7:0] nxt_div_cnt;
    logic       derived_ff;
    logic       nxt_derived;
    logic       ref_s1_ff;
    logic       ref_s2_ff;
    logic       ref_s3_ff;
    logic       ref_prev_ff;
    logic       slow_sel;

    always_comb
    begin
        nxt_div_cnt = div_cnt_ff;
        nxt_derived = derived_ff;
        // Divider runs only while no slow clock is fitted
        if (clk_sel_ff.slow_clock_absent && ref_s3_ff && !ref_prev_ff)
        begin
            if (div_cnt_ff == DIV_LAST)
            begin
                nxt_div_cnt = 8'h00;
                nxt_derived = !derived_ff;
            end
            else
                nxt_div_cnt = div_cnt_ff + 8'h01;
        end
        slow_sel = clk_sel_ff.slow_clock_absent ? derived_ff : sync_lvl[6];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            div_cnt_ff               <= 8'h00;
            derived_ff               <= 1'b0;
            ref_s1_ff                <= 1'b0;
            ref_s2_ff                <= 1'b0;
            ref_s3_ff                <= 1'b0;
            ref_prev_ff              <= 1'b0;
            slow_clk_out_ff          <= 1'b0;
            key_wake_clk_ff          <= 1'b0;
            specific_key_wake_off_ff <= 1'b0;
            fast_clock_out_en_ff     <= 1'b0;
        end
        else
        begin
            div_cnt_ff               <= nxt_div_cnt;
            derived_ff               <= nxt_derived;
            // Reference too fast for the agreement filter: a phase may give one sample
            ref_s1_ff                <= fast_ref_in;
            ref_s2_ff                <= ref_s1_ff;
            ref_s3_ff                <= ref_s2_ff;
            ref_prev_ff              <= ref_s3_ff;
            slow_clk_out_ff          <= slow_sel;
            key_wake_clk_ff          <= slow_sel & !clk_sel_ff.specific_key_wake_off;
            specific_key_wake_off_ff <= clk_sel_ff.specific_key_wake_off;
            fast_clock_out_en_ff     <= !clk_sel_ff.fast_clock_out_off;
        end
    end

    // Interrupt polarity and routing
    logic [15:0] nxt_serirq;

    assign nxt_serirq[0] = 1'b0;
    for (genvar n = 1; n < gcicr_pkg::NUM_SIRQ; n++)
    begin : g_sirq
        assign nxt_serirq[n] = (sync_lvl[7] && route_ff.sel_a == 4'(n))
                             | (sync_lvl[8] && route_ff.sel_b == 4'(n));
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            serirq_req_ff  <= 16'h0000;
            irq2_routed_ff <= 1'b0;
            rtc_irq_out_ff <= 1'b0;
        end
        else
        begin
            serirq_req_ff  <= nxt_serirq;
            // Flags slot sharing for the management interrupt logic
            irq2_routed_ff <= (route_ff.sel_a == gcicr_pkg::ROUTE_SMI_SHARED)
                            | (route_ff.sel_b == gcicr_pkg::ROUTE_SMI_SHARED);
            rtc_irq_out_ff <= rtc_irq_in ^ rtc_pol_ff[gcicr_pkg::RTC_INV_BIT];
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_route_write;
        bus_req.wr && bus_req.addr == gcicr_pkg::OFS_IRQ_INPUT_ROUTING;
    endsequence

    sequence s_clock_write_off;
        bus_req.wr && bus_req.addr == gcicr_pkg::OFS_CLOCK_SOURCE_CTRL
            && bus_req.wdata[2];
    endsequence

    a_dir_input_released: assert property (
        1'b1 |=> ((gpio_pin_oe_n_ff & $past(cfg_in)) == $past(cfg_in)))
        else $error("input pin is driven");
    a_pol_output_level: assert property (
        1'b1 |=> (gpio_pin_out_ff == ($past(gpio_core_out) ^ $past(cfg_inv))))
        else $error("pin output polarity wrong");
    a_od_no_high: assert property (
        1'b1 |=> ((~gpio_pin_oe_n_ff & $past(cfg_od) & gpio_pin_out_ff) == 6'h00))
        else $error("open-drain pin driven high");
    a_slow_src_select: assert property (
        clk_sel_ff.slow_clock_absent |=> (slow_clk_out_ff == $past(derived_ff)))
        else $error("slow clock not taken from divider");
    a_key_clk_gated: assert property (
        clk_sel_ff.specific_key_wake_off [*2] |=> !key_wake_clk_ff)
        else $error("key wake clock not gated");
    a_fast_out_off: assert property (
        s_clock_write_off ##1 1'b1 |=> !fast_clock_out_en_ff)
        else $error("fast clock output still on");
    a_rtc_polarity: assert property (
        1'b1 |=> (rtc_irq_out_ff == ($past(rtc_irq_in) ^ $past(rtc_pol_ff[0]))))
        else $error("rtc interrupt polarity wrong");
    a_route_b_sel: assert property (
        s_route_write ##1 (sync_lvl[8] && route_ff.sel_b != 4'h0)
            |=> serirq_req_ff[$past(route_ff.sel_b)])
        else $error("input B not routed");
    a_route_a_sel: assert property (
        s_route_write ##1 (sync_lvl[7] && route_ff.sel_a != 4'h0)
            |=> serirq_req_ff[$past(route_ff.sel_a)])
        else $error("input A not routed");
    a_route_none: assert property (
        (route_ff == 8'h00) |=> (serirq_req_ff == 16'h0000))
        else $error("request raised with no route");
    a_reset_defaults: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        !rst_n |=> (gpio_cfg_ff[0] == gcicr_pkg::RST_GPIO_CTRL
                    && clk_sel_ff == gcicr_pkg::RST_CLOCK_CTRL && route_ff == 8'h00))
        else $error("register not at reset value");
endmodule

/* core/gcicr_pkg.sv */
// Package: offsets, reset values, field layouts and timing for the config register bank
package gcicr_pkg;

    localparam int unsigned ADDR_W    = 8;
    localparam int unsigned DATA_W    = 8;
    localparam int unsigned NUM_PINS  = 6;
    localparam int unsigned ROUTE_W   = 4;
    localparam int unsigned NUM_SIRQ  = 16;

    // Register offsets
    localparam logic [7:0] OFS_GPIO_PIN_82_CTRL = 8'hEA;
    localparam logic [7:0] OFS_GPIO_PIN_83_CTRL = 8'hEB;
    localparam logic [7:0] OFS_GPIO_PIN_84_CTRL = 8'hEC;
    localparam logic [7:0] OFS_GPIO_PIN_85_CTRL = 8'hED;
    localparam logic [7:0] OFS_GPIO_PIN_86_CTRL = 8'hEE;
    localparam logic [7:0] OFS_GPIO_PIN_87_CTRL = 8'hEF;
    localparam logic [7:0] OFS_CLOCK_SOURCE_CTRL = 8'hF0;
    localparam logic [7:0] OFS_RTC_IRQ_POLARITY  = 8'hF1;
    localparam logic [7:0] OFS_IRQ_INPUT_ROUTING = 8'hF4;
    localparam logic [7:0] OFS_PIN_LEVEL_STATUS  = 8'hF5;

    localparam logic [7:0] GPIO_OFS [NUM_PINS] = '{
        OFS_GPIO_PIN_82_CTRL, OFS_GPIO_PIN_83_CTRL, OFS_GPIO_PIN_84_CTRL,
        OFS_GPIO_PIN_85_CTRL, OFS_GPIO_PIN_86_CTRL, OFS_GPIO_PIN_87_CTRL
    };

    // Reset values
    localparam logic [7:0] RST_GPIO_CTRL   = 8'h80;
    localparam logic [7:0] RST_CLOCK_CTRL  = 8'h00;
    localparam logic [7:0] RST_RTC_POL     = 8'h00;
    localparam logic [7:0] RST_IRQ_ROUTING = 8'h00;

    // Writable bits; reserved bits stay zero
    localparam logic [7:0] MASK_GPIO_CTRL   = 8'h83;
    localparam logic [7:0] MASK_CLOCK_CTRL  = 8'h07;
    localparam logic [7:0] MASK_RTC_POL     = 8'h01;
    localparam logic [7:0] MASK_IRQ_ROUTING = 8'hFF;

    localparam int unsigned RTC_INV_BIT = 0;

    // Routing code shared with the system-management interrupt
    localparam logic [3:0] ROUTE_SMI_SHARED = 4'h2;

    // Clock rates, Hz
    localparam int unsigned SYS_CLK_HZ  = 40_000_000;
    localparam int unsigned FAST_REF_HZ = 14_318_180;
    localparam int unsigned SLOW_CLK_HZ = 32_768;
    // Reference edges per half period of the derived slow clock
    localparam int unsigned SLOW_HALF_EDGES = FAST_REF_HZ / (2 * SLOW_CLK_HZ);

    typedef struct packed {
        logic       open_drain;
        logic [4:0] rsvd;
        logic       invert;
        logic       is_input;
    } gcicr_pin_cfg_s;

    typedef struct packed {
        logic [4:0] rsvd;
        logic       fast_clock_out_off;
        logic       specific_key_wake_off;
        logic       slow_clock_absent;
    } gcicr_clk_sel_s;

    typedef struct packed {
        logic [3:0] sel_b;
        logic [3:0] sel_a;
    } gcicr_route_s;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } gcicr_bus_req_s;

endpackage

/* core/gcicr_sync.sv */
// Three-stage synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module gcicr_sync #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Asynchronous inputs
    input  wire logic [WIDTH-1:0] async_in,
    // Filtered levels
    output logic      [WIDTH-1:0] level_ff
);
    logic [WIDTH-1:0] s1_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] nxt_level;

    always_comb
    begin
        nxt_level = ((s2_ff ~^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & level_ff);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
        begin
            s1_ff    <= '0;
            s2_ff    <= '0;
            s3_ff    <= '0;
            level_ff <= '0;
        end
        else
        begin
            s1_ff    <= async_in;
            s2_ff    <= s1_ff;
            s3_ff    <= s2_ff;
            level_ff <= nxt_level;
        end
    end
endmodule

/* bench/tb.sv */
// Self-checking testbench for the GPIO, clock, RTC and routing config registers
`timescale 1ns/1ps
module tb;
    logic                      clk_sys;
    logic                      rst_n;
    gcicr_pkg::gcicr_bus_req_s bus_req;
    logic [7:0]                rdata_ff;
    logic [5:0]                pin_in;
    logic [5:0]                pin_out;
    logic [5:0]                oe_n;
    logic [5:0]                core_out;
    logic [5:0]                core_in;
    logic                      slow_in;
    logic                      fast_ref;
    logic                      slow_out;
    logic                      key_clk;
    logic                      key_off;
    logic                      fast_en;
    logic                      rtc_in;
    logic                      rtc_out;
    logic                      ext_a;
    logic                      ext_b;
    logic [15:0]               serirq;
    logic                      irq2;
    int                        err_count;
    int                        compares;

    gcicr_regs dut (
        .clk_sys                  (clk_sys),
        .rst_n                    (rst_n),
        .bus_req                  (bus_req),
        .rdata_ff                 (rdata_ff),
        .gpio_pin_in              (pin_in),
        .gpio_pin_out_ff          (pin_out),
        .gpio_pin_oe_n_ff         (oe_n),
        .gpio_core_out            (core_out),
        .gpio_core_in_ff          (core_in),
        .slow_clock_in            (slow_in),
        .fast_ref_in              (fast_ref),
        .slow_clk_out_ff          (slow_out),
        .key_wake_clk_ff          (key_clk),
        .specific_key_wake_off_ff (key_off),
        .fast_clock_out_en_ff     (fast_en),
        .rtc_irq_in               (rtc_in),
        .rtc_irq_out_ff           (rtc_out),
        .ext_interrupt_in_a       (ext_a),
        .ext_interrupt_in_b       (ext_b),
        .serirq_req_ff            (serirq),
        .irq2_routed_ff           (irq2)
    );

    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Free-running 14 MHz reference, unrelated in phase to the system clock
    initial
    begin
        fast_ref = 1'b0;
        forever #35 fast_ref = ~fast_ref;
    end

    task automatic finish_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe, then falls to zero
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(negedge clk_sys);
        chk("rdata", {8'h00, exp}, {8'h00, rdata_ff});
        @(negedge clk_sys);
        chk("rdata idle", 16'h0000, {8'h00, rdata_ff});
    endtask

    task automatic pins_cfg(input logic [7:0] d);
        int i;
        for (i = 0; i < 6; i++)
            wr(gcicr_pkg::GPIO_OFS[i], d);
    endtask

    task automatic do_reset();
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask

    task automatic t_defaults();
        int i;
        for (i = 0; i < 6; i++)
            rd(gcicr_pkg::GPIO_OFS[i], 8'h80);
        rd(8'hF0, 8'h00);
        rd(8'hF1, 8'h00);
        rd(8'hF4, 8'h00);
        // Reset leaves open-drain outputs, released where the level is high
        chk("oe_n reset", {10'h000, core_out}, {10'h000, oe_n});
        chk("fast_en", 16'h0001, {15'h0000, fast_en});
        $display("test defaults done");
    endtask

    task automatic t_masks();
        pins_cfg(8'hFF);
        rd(8'hEA, 8'h83);
        rd(8'hEF, 8'h83);
        wr(8'hF0, 8'hFF);
        rd(8'hF0, 8'h07);
        wr(8'hF1, 8'hFF);
        rd(8'hF1, 8'h01);
        wr(8'hF4, 8'hFF);
        rd(8'hF4, 8'hFF);
        wr(8'hF2, 8'h5A);
        rd(8'hF2, 8'h00);
        rd(8'hE9, 8'h00);
        wr(8'hF0, 8'h00);
        wr(8'hF1, 8'h00);
        $display("test masks done");
    endtask

    task automatic t_gpio();
        pins_cfg(8'h00);
        @(posedge clk_sys);
        core_out <= 6'h2A;
        cyc(3);
        chk("pin_out", 16'h002A, {10'h000, pin_out});
        chk("oe_n", 16'h0000, {10'h000, oe_n});
        pins_cfg(8'h02);
        cyc(3);
        chk("pin_out inv", 16'h0015, {10'h000, pin_out});
        pins_cfg(8'h80);
        cyc(3);
        chk("oe_n od", 16'h002A, {10'h000, oe_n});
        pins_cfg(8'h03);
        @(posedge clk_sys);
        pin_in <= 6'h0F;
        cyc(8);
        chk("oe_n in", 16'h003F, {10'h000, oe_n});
        chk("core_in inv", 16'h0030, {10'h000, core_in});
        rd(8'hF5, 8'h30);
        pins_cfg(8'h01);
        cyc(3);
        chk("core_in", 16'h000F, {10'h000, core_in});
        $display("test gpio done");
    endtask

    task automatic t_rtc();
        @(posedge clk_sys);
        rtc_in <= 1'b1;
        cyc(3);
        chk("rtc high", 16'h0001, {15'h0000, rtc_out});
        wr(8'hF1, 8'h01);
        cyc(3);
        chk("rtc inv", 16'h0000, {15'h0000, rtc_out});
        @(posedge clk_sys);
        rtc_in <= 1'b0;
        cyc(3);
        chk("rtc low", 16'h0001, {15'h0000, rtc_out});
        $display("test rtc done");
    endtask

    task automatic t_route();
        int          c;
        logic [15:0] exp;
        for (c = 0; c < 16; c++)
        begin
            exp = (c == 0) ? 16'h0000 : (16'h0001 << c);
            wr(8'hF4, {4'h0, c[3:0]});
            @(posedge clk_sys);
            ext_a <= 1'b1;
            cyc(8);
            chk("route a", exp, serirq);
            chk("irq2 a", {15'h0000, c == 2}, {15'h0000, irq2});
            wr(8'hF4, {c[3:0], 4'h0});
            @(posedge clk_sys);
            ext_a <= 1'b0;
            ext_b <= 1'b1;
            cyc(8);
            chk("route b", exp, serirq);
            chk("irq2 b", {15'h0000, c == 2}, {15'h0000, irq2});
            @(posedge clk_sys);
            ext_a <= 1'b1;
            cyc(8);
            // Route both while both inputs are high; A takes the inverse code
            wr(8'hF4, {c[3:0], ~c[3:0]});
            cyc(3);
            exp = exp | ((c == 15) ? 16'h0000 : (16'h0001 << (15 - c)));
            chk("route ab", exp, serirq);
            chk("irq2 ab", {15'h0000, c == 2 || c == 13}, {15'h0000, irq2});
            @(posedge clk_sys);
            ext_a <= 1'b0;
            ext_b <= 1'b0;
            cyc(8);
            chk("route idle", 16'h0000, serirq);
        end
        $display("test routing done");
    endtask

    // Cycles until the slow clock output next changes; a stuck output ends the run
    task automatic wait_flip(output int n);
        logic s;
        s = slow_out;
        n = 0;
        while (slow_out === s && n < 2000)
        begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 2000)
        begin
            err_count++;
            $display("CHECK FAILED slow clock expected toggle seen none");
            finish_test();
        end
    endtask

    task automatic t_clocks();
        int n;
        @(posedge clk_sys);
        slow_in <= 1'b1;
        cyc(8);
        chk("slow out", 16'h0001, {15'h0000, slow_out});
        chk("key clk", 16'h0001, {15'h0000, key_clk});
        wr(8'hF0, 8'h02);
        cyc(3);
        chk("key clk off", 16'h0000, {15'h0000, key_clk});
        chk("key off", 16'h0001, {15'h0000, key_off});
        wr(8'hF0, 8'h04);
        cyc(3);
        chk("fast_en off", 16'h0000, {15'h0000, fast_en});
        chk("key clk on", 16'h0001, {15'h0000, key_clk});
        wr(8'hF0, 8'h01);
        // First flips may be the source switch and a partial half period
        wait_flip(n);
        wait_flip(n);
        wait_flip(n);
        chk("slow half period ok", 16'h0001, {15'h0000, n >= 605 && n <= 616});
        $display("test clocks done");
    endtask

    initial
    begin
        rst_n     = 1'b0;
        bus_req   = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'h00};
        pin_in    = 6'h00;
        core_out  = 6'h00;
        slow_in   = 1'b0;
        rtc_in    = 1'b0;
        ext_a     = 1'b0;
        ext_b     = 1'b0;
        err_count = 0;
        compares  = 0;
        do_reset();
        t_defaults();
        t_masks();
        t_gpio();
        t_rtc();
        t_route();
        t_clocks();
        pins_cfg(8'h03);
        do_reset();
        t_defaults();
        finish_test();
    end
endmodule
